// file: design/byte_arith_logic_unit.sv
// Byte arithmetic and logic datapath with a Wishbone classic register slave.
// Assumes one 40 MHz clock, a synchronous Wishbone master and an asynchronous reset.
// Notes on behaviour
// - Add sums destination and source, plus carry if chosen, and sets Z C N V H in one clock.
// - Word add adds the immediate to the high:low pair, sets Z C N V S, and takes two clocks.
// - Subtract takes a source or immediate from the destination, sets Z C N V H in one clock.
// - Borrow subtract takes source and carry from destination, sets Z C N V H in one clock.
// - Immediate borrow subtract takes immediate and carry from destination in one clock.
// - Word subtract takes the immediate from the pair, sets Z C N V S, and takes two clocks.
// - AND with a source or immediate writes the destination and touches only Z N V.
// - OR with a source or immediate writes the destination and sets Z N V in one clock.
// - Set bits ORs the immediate mask into the destination, sets Z N V in one clock.
// - Clear bits ANDs the destination with 0xFF minus the mask, sets Z N V in one clock.
// - Test leaves the destination as it is and sets Z N V from it in one clock.
//
// Added by the designer: the placing of the registers and the Wishbone register port.
`timescale 1ns/100ps
`include "alu_cfg.svh"

module byte_arith_logic_unit
  import alu_pkg::*;
#(
  parameter int ADDR_W = 8
)
(
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic rst,
  // Wishbone classic slave.
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADDR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o
);

  state_e state_r;
  opcode_e op_r;
  logic [7:0] regDest_r;
  logic [7:0] regSrc_r;
  logic [7:0] regHigh_r;
  logic [5:0] flags_r;
  logic lowCarry_r;
  logic [7:0] resNxt;
  logic [5:0] flagsNxt;
  logic lowCarryNxt;
  logic updFlags;
  logic busReq;
  logic busWr;
  logic [7:0] wordAdr;

  // One 8-bit add or subtract step with carry or borrow in, giving carry, half and overflow.
  function automatic arith_s arith(input logic [7:0] a, input logic [7:0] b,
                                   input logic cin, input logic sub);
    arith_s r;
    logic [8:0] full;
    logic [4:0] nib;
    if (sub)
    begin
      full = {1'b0, a} - {1'b0, b} - {8'h00, cin};
      nib = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, cin};
      r.v = (a[7] & ~b[7] & ~full[7]) | (~a[7] & b[7] & full[7]);
    end
    else
    begin
      full = {1'b0, a} + {1'b0, b} + {8'h00, cin};
      nib = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
      r.v = (a[7] & b[7] & ~full[7]) | (~a[7] & ~b[7] & full[7]);
    end
    r.res = full[7:0];
    r.c = full[8];
    r.h = nib[4];
    return r;
  endfunction : arith

  function automatic logic isWordOp(input opcode_e op);
    return (op == OpWordImmAdd) || (op == OpWordImmSubtract);
  endfunction : isWordOp

  assign busReq = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  // Writes land only while the datapath is idle, so operands never change mid-operation.
  assign busWr = busReq & wb_we_i & wb_sel_i[0] & (state_r == StIdle);
  assign wordAdr = {wb_adr_i[7:2], 2'b00};

  // Bus answer: one registered acknowledge per request, unmapped reads return zero.
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end
    else
    begin
      wb_ack_o <= busReq;
      if (busReq && !wb_we_i)
      begin
        case (wordAdr)
          `ALU_CTRL_OFS: wb_dat_o <= {27'h0000000, op_r};
          `ALU_DEST_OFS: wb_dat_o <= {24'h000000, regDest_r};
          `ALU_SRC_OFS: wb_dat_o <= {24'h000000, regSrc_r};
          `ALU_HIGH_OFS: wb_dat_o <= {24'h000000, regHigh_r};
          `ALU_FLAGS_OFS: wb_dat_o <= {23'h000000, (state_r != StIdle), 2'b00, flags_r};
          default: wb_dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Sequencer: a control write starts an operation; word operations take a second clock.
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      state_r <= StIdle;
      op_r <= opcode_e'(`ALU_OPCODE_RST);
    end
    else
    begin
      case (state_r)
        StIdle:
        begin
          if (busWr && wordAdr == `ALU_CTRL_OFS)
          begin
            op_r <= opcode_e'(wb_dat_i[4:0]);
            state_r <= StExec;
          end
        end
        StExec: state_r <= isWordOp(op_r) ? StHigh : StIdle;
        StHigh: state_r <= StIdle;
        default: state_r <= StIdle;
      endcase
    end
  end

  // Result and flag computation for the current step.
  always_comb
  begin
    arith_s sum;
    logic useC;
    logic useH;
    logic vOut;
    // Starting from the destination keeps it unchanged for codes with no operation.
    sum = arith(regDest_r, 8'h00, 1'b0, 1'b0);
    resNxt = regDest_r;
    flagsNxt = flags_r;
    lowCarryNxt = lowCarry_r;
    updFlags = 1'b0;
    useC = 1'b0;
    useH = 1'b0;
    vOut = 1'b0;
    if (state_r == StHigh)
    begin
      // High byte of the pair takes the carry or borrow of the low byte.
      sum = arith(regHigh_r, 8'h00, lowCarry_r, op_r == OpWordImmSubtract);
      resNxt = sum.res;
      updFlags = 1'b1;
      flagsNxt[`ALU_FLAG_C] = sum.c;
      flagsNxt[`ALU_FLAG_Z] = (sum.res == 8'h00) && (regDest_r == 8'h00);
      flagsNxt[`ALU_FLAG_N] = sum.res[7];
      flagsNxt[`ALU_FLAG_V] = sum.v;
      flagsNxt[`ALU_FLAG_S] = sum.res[7] ^ sum.v;
    end
    else if (state_r == StExec)
    begin
      updFlags = 1'b1;
      case (op_r)
        OpAdd, OpAddCarry:
        begin
          sum = arith(regDest_r, regSrc_r, (op_r == OpAddCarry) & flags_r[`ALU_FLAG_C], 1'b0);
          useC = 1'b1;
          useH = 1'b1;
        end
        OpRegSubtract, OpImmSubtract:
        begin
          sum = arith(regDest_r, regSrc_r, 1'b0, 1'b1);
          useC = 1'b1;
          useH = 1'b1;
        end
        OpRegBorrowSubtract, OpImmBorrowSubtract:
        begin
          sum = arith(regDest_r, regSrc_r, flags_r[`ALU_FLAG_C], 1'b1);
          useC = 1'b1;
          useH = 1'b1;
        end
        OpWordImmAdd, OpWordImmSubtract:
        begin
          sum = arith(regDest_r, regSrc_r, 1'b0, op_r == OpWordImmSubtract);
          updFlags = 1'b0;
          lowCarryNxt = sum.c;
        end
        OpRegAnd, OpImmAndMask: sum.res = regDest_r & regSrc_r;
        OpRegOr, OpImmOrMask: sum.res = regDest_r | regSrc_r;
        OpSetBitsReg: sum.res = regDest_r | regSrc_r;
        OpClearBitsReg: sum.res = regDest_r & (8'hFF - regSrc_r);
        OpSignZeroCheck: sum.res = regDest_r & regDest_r;
        OpXorRegisters: sum.res = regDest_r ^ regSrc_r;
        OpZeroRegister: sum.res = regDest_r ^ regDest_r;
        OpBitwiseInvert:
        begin
          sum.res = 8'hFF - regDest_r;
          sum.c = 1'b1;
          useC = 1'b1;
        end
        OpZeroMinusValue:
        begin
          sum = arith(8'h00, regDest_r, 1'b0, 1'b1);
          useC = 1'b1;
          useH = 1'b1;
        end
        OpIncrement:
        begin
          sum.res = regDest_r + 8'h01;
          sum.v = (sum.res == 8'h80);
        end
        OpMinusOne:
        begin
          sum.res = regDest_r - 8'h01;
          sum.v = (sum.res == 8'h7F);
        end
        default: updFlags = 1'b0;
      endcase
      resNxt = sum.res;
      vOut = sum.v;
      if (updFlags)
      begin
        flagsNxt[`ALU_FLAG_Z] = (sum.res == 8'h00);
        flagsNxt[`ALU_FLAG_N] = sum.res[7];
        flagsNxt[`ALU_FLAG_V] = vOut;
        flagsNxt[`ALU_FLAG_C] = useC ? sum.c : flags_r[`ALU_FLAG_C];
        flagsNxt[`ALU_FLAG_H] = useH ? sum.h : flags_r[`ALU_FLAG_H];
      end
    end
  end

  // Destination, source and high operand registers.
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      regDest_r <= `ALU_BYTE_RST;
      regSrc_r <= `ALU_BYTE_RST;
      regHigh_r <= `ALU_BYTE_RST;
      lowCarry_r <= 1'b0;
    end
    else
    begin
      lowCarry_r <= lowCarryNxt;
      if (state_r == StExec)
      begin
        regDest_r <= resNxt;
      end
      else if (state_r == StHigh)
      begin
        regHigh_r <= resNxt;
      end
      else if (busWr)
      begin
        case (wordAdr)
          `ALU_DEST_OFS: regDest_r <= wb_dat_i[7:0];
          `ALU_SRC_OFS: regSrc_r <= wb_dat_i[7:0];
          `ALU_HIGH_OFS: regHigh_r <= wb_dat_i[7:0];
          default: ;
        endcase
      end
    end
  end

  // Status flags: updated by operations, and writable by software while idle.
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      flags_r <= `ALU_FLAGS_RST;
    end
    else if (updFlags)
    begin
      flags_r <= flagsNxt;
    end
    else if (busWr && wordAdr == `ALU_FLAGS_OFS)
    begin
      flags_r <= wb_dat_i[5:0];
    end
  end

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  sequence s_word_add;
    (state_r == StExec && op_r == OpWordImmAdd) ##1 (state_r == StHigh);
  endsequence

  sequence s_word_sub;
    (state_r == StExec && op_r == OpWordImmSubtract) ##1 (state_r == StHigh);
  endsequence

  property p_add_sum;
    (state_r == StExec && op_r == OpAdd) |=>
      regDest_r == 8'($past(regDest_r) + $past(regSrc_r)) && state_r == StIdle;
  endproperty
  a_add_sum: assert property (p_add_sum) else $error("add result wrong");
  property p_add_carry;
    (state_r == StExec && op_r == OpAddCarry) |=>
      regDest_r == 8'($past(regDest_r) + $past(regSrc_r) + {7'h00, $past(flags_r[0])});
  endproperty
  a_add_carry: assert property (p_add_carry) else $error("add with carry wrong");
  property p_word_add;
    s_word_add |=> state_r == StIdle && {regHigh_r, regDest_r} ==
      16'($past({regHigh_r, regDest_r}, 2) + {8'h00, $past(regSrc_r, 2)});
  endproperty
  a_word_add: assert property (p_word_add) else $error("word add wrong");
  property p_sub_borrow;
    (state_r == StExec && op_r == OpImmSubtract) |=>
      regDest_r == 8'($past(regDest_r) - $past(regSrc_r)) &&
      flags_r[`ALU_FLAG_C] == ($past(regDest_r) < $past(regSrc_r));
  endproperty
  a_sub_borrow: assert property (p_sub_borrow) else $error("subtract wrong");
  property p_reg_borrow_sub;
    (state_r == StExec && op_r == OpRegBorrowSubtract) |=>
      regDest_r == 8'($past(regDest_r) - $past(regSrc_r) - {7'h00, $past(flags_r[0])});
  endproperty
  a_reg_borrow_sub: assert property (p_reg_borrow_sub) else $error("borrow sub wrong");
  property p_imm_borrow_c;
    (state_r == StExec && op_r == OpImmBorrowSubtract) |=> flags_r[`ALU_FLAG_C] ==
      ({1'b0, $past(regDest_r)} < 9'({1'b0, $past(regSrc_r)} + {8'h00, $past(flags_r[0])}));
  endproperty
  a_imm_borrow_c: assert property (p_imm_borrow_c) else $error("borrow flag wrong");
  property p_word_sub;
    s_word_sub |=>
      {regHigh_r, regDest_r} == 16'($past({regHigh_r, regDest_r}, 2) - {8'h00, $past(regSrc_r, 2)})
      && flags_r[`ALU_FLAG_S] == (flags_r[`ALU_FLAG_N] ^ flags_r[`ALU_FLAG_V]);
  endproperty
  a_word_sub: assert property (p_word_sub) else $error("word subtract wrong");
  property p_and_flags;
    (state_r == StExec && op_r == OpImmAndMask) |=> !flags_r[`ALU_FLAG_V] &&
      $stable(flags_r[`ALU_FLAG_C]) && regDest_r == ($past(regDest_r) & $past(regSrc_r));
  endproperty
  a_and_flags: assert property (p_and_flags) else $error("and result or flags wrong");
  property p_clear_bits;
    (state_r == StExec && op_r == OpClearBitsReg) |=>
      regDest_r == ($past(regDest_r) & ~$past(regSrc_r));
  endproperty
  a_clear_bits: assert property (p_clear_bits) else $error("clear bits wrong");
  property p_test_keeps;
    (state_r == StExec && op_r == OpSignZeroCheck) |=>
      $stable(regDest_r) && flags_r[`ALU_FLAG_Z] == (regDest_r == 8'h00);
  endproperty
  a_test_keeps: assert property (p_test_keeps) else $error("test changed value");
  property p_invert_carry;
    (state_r == StExec && op_r == OpBitwiseInvert) |=>
      flags_r[`ALU_FLAG_C] && regDest_r == ~$past(regDest_r);
  endproperty
  a_invert_carry: assert property (p_invert_carry) else $error("invert wrong");
  property p_inc_overflow;
    (state_r == StExec && op_r == OpIncrement) |=>
      flags_r[`ALU_FLAG_V] == ($past(regDest_r) == 8'h7F) && $stable(flags_r[`ALU_FLAG_C]);
  endproperty
  a_inc_overflow: assert property (p_inc_overflow) else $error("increment wrong");

endmodule : byte_arith_logic_unit

// file: design/alu_cfg.svh
// Constants of the byte arithmetic and logic unit: register offsets, flag positions,
// reset values and cycle counts. Included by the datapath module and the testbench.
`ifndef ALU_CFG_SVH
`define ALU_CFG_SVH

// Register byte offsets on the Wishbone bus, one aligned word each.
`define ALU_CTRL_OFS 8'h00
`define ALU_DEST_OFS 8'h04
`define ALU_SRC_OFS 8'h08
`define ALU_HIGH_OFS 8'h0C
`define ALU_FLAGS_OFS 8'h10

// Status flag positions inside the flags register.
`define ALU_FLAG_C 0
`define ALU_FLAG_Z 1
`define ALU_FLAG_N 2
`define ALU_FLAG_V 3
`define ALU_FLAG_S 4
`define ALU_FLAG_H 5
`define ALU_BUSY_BIT 8

// Reset values.
`define ALU_FLAGS_RST 6'h00
`define ALU_BYTE_RST 8'h00
`define ALU_OPCODE_RST 5'h00

// Execution length in clocks.
`define ALU_BYTE_CLOCKS 1
`define ALU_WORD_CLOCKS 2

`endif

// file: design/alu_pkg.sv
// Types of the byte arithmetic and logic unit: operation codes, sequencer states and
// the result of one 8-bit add or subtract step.
package alu_pkg;

  typedef enum logic [4:0] {
    OpAdd = 5'b00000,
    OpAddCarry = 5'b00001,
    OpWordImmAdd = 5'b00010,
    OpRegSubtract = 5'b00011,
    OpImmSubtract = 5'b00100,
    OpRegBorrowSubtract = 5'b00101,
    OpImmBorrowSubtract = 5'b00110,
    OpWordImmSubtract = 5'b00111,
    OpRegAnd = 5'b01000,
    OpImmAndMask = 5'b01001,
    OpRegOr = 5'b01010,
    OpImmOrMask = 5'b01011,
    OpXorRegisters = 5'b01100,
    OpBitwiseInvert = 5'b01101,
    OpZeroMinusValue = 5'b01110,
    OpSetBitsReg = 5'b01111,
    OpClearBitsReg = 5'b10000,
    OpIncrement = 5'b10001,
    OpMinusOne = 5'b10010,
    OpSignZeroCheck = 5'b10011,
    OpZeroRegister = 5'b10100
  } opcode_e;

  typedef enum logic [1:0] {
    StIdle = 2'b00,
    StExec = 2'b01,
    StHigh = 2'b10
  } state_e;

  typedef struct packed {
    logic [7:0] res;
    logic c;
    logic h;
    logic v;
  } arith_s;

endpackage : alu_pkg

// file: verification/wb_host_model.sv
// Wishbone classic master standing in for the decoder and register file side.
// Assumes a slave that acks every request; the bench owns the timeout.
`timescale 1ns/100ps

module wb_host_model
(
  // Clock.
  input wire logic sysClk,
  // Wishbone master side.
  output logic wbCyc,
  output logic wbStb,
  output logic wbWe,
  output logic [7:0] wbAdr,
  output logic [3:0] wbSel,
  output logic [31:0] wbDatW,
  input wire logic [31:0] wbDatR,
  input wire logic wbAck
);

  initial
  begin
    wbCyc = 1'b0;
    wbStb = 1'b0;
    wbWe = 1'b0;
    wbAdr = 8'h00;
    wbSel = 4'h0;
    wbDatW = 32'h0;
  end

  // One classic cycle; the request is held until the edge that samples ack high.
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] s, output logic [31:0] q);
    @(posedge sysClk);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= w;
    wbAdr <= a;
    wbSel <= s;
    wbDatW <= d;
    wait (wbAck === 1'b1);
    @(posedge sysClk);
    q = wbDatR;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    wbWe <= 1'b0;
    // Released address and data lines show the inverse so that stale values cannot pass.
    wbAdr <= ~a;
    wbDatW <= ~d;
  endtask : xfer

endmodule : wb_host_model

// file: verification/byte_arith_logic_unit_tb.sv
// Self-checking bench: random and boundary operands for every opcode, checked
// against an integer model. Assumes the Wishbone register map of the unit.
`timescale 1ns/100ps
`include "alu_cfg.svh"

module byte_arith_logic_unit_tb;
  import alu_pkg::*;

  logic sysClk = 1'b0;
  logic rst = 1'b1;
  logic wbCyc;
  logic wbStb;
  logic wbWe;
  logic [7:0] wbAdr;
  logic [3:0] wbSel;
  logic [31:0] wbDatW;
  logic [31:0] wbDatR;
  logic wbAck;
  int miscompares = 0;
  int checkCount = 0;
  int seed;
  int d;
  int s;
  int hi;
  logic [5:0] f;
  int edges [4] = '{0, 255, 128, 127};

  always #12.5 sysClk = ~sysClk;

  byte_arith_logic_unit byte_arith_logic_unit_i (.sys_clk(sysClk), .rst(rst),
    .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr),
    .wb_sel_i(wbSel), .wb_dat_i(wbDatW), .wb_dat_o(wbDatR), .wb_ack_o(wbAck));

  wb_host_model wb_host_model_i (.sysClk(sysClk), .wbCyc(wbCyc), .wbStb(wbStb),
    .wbWe(wbWe), .wbAdr(wbAdr), .wbSel(wbSel), .wbDatW(wbDatW), .wbDatR(wbDatR),
    .wbAck(wbAck));

  task automatic write_reg(input logic [7:0] a, input int v, input logic [3:0] sl = 4'hF);
    logic [31:0] q;
    wb_host_model_i.xfer(1'b1, a, 32'(v), sl, q);
  endtask : write_reg

  task automatic read_check(input logic [7:0] a, input int v);
    logic [31:0] q;
    wb_host_model_i.xfer(1'b0, a, 32'h0, 4'hF, q);
    checkCount++;
    if (q !== 32'(v))
    begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, q, 32'(v));
    end
  endtask : read_check

  // Integer model of one operation on destination, high byte and flags.
  function automatic void model(input int op, input int sv, inout int dv, inout int hv,
                                inout logic [5:0] fl);
    int a;
    int b;
    int c;
    int r;
    int w;
    int x;
    a = (op == 14) ? 0 : dv;
    b = (op == 14) ? dv : sv;
    c = (op inside {1, 5, 6}) ? int'(fl[`ALU_FLAG_C]) : 0;
    if (op inside {2, 7})
    begin
      w = hv * 256 + dv;
      x = (op == 2) ? w + sv : w - sv;
      fl[`ALU_FLAG_C] = (x > 65535) || (x < 0);
      x = x & 65535;
      fl[`ALU_FLAG_Z] = (x == 0);
      fl[`ALU_FLAG_N] = x[15];
      fl[`ALU_FLAG_V] = (op == 2) ? (!w[15] && x[15]) : (w[15] && !x[15]);
      fl[`ALU_FLAG_S] = x[15] ^ fl[`ALU_FLAG_V];
      dv = x & 255;
      hv = x >> 8;
      return;
    end
    if (op inside {0, 1, 3, 4, 5, 6, 14})
    begin
      r = (op < 2) ? a + b + c : a - b - c;
      fl[`ALU_FLAG_H] = (op < 2) ? (a % 16 + b % 16 + c > 15) : (a % 16 < b % 16 + c);
      fl[`ALU_FLAG_C] = (r > 255) || (r < 0);
      fl[`ALU_FLAG_V] = ((a[7] == b[7]) == (op < 2)) && (r[7] != a[7]);
      r = r & 255;
    end
    else
    begin
      case (op)
        8, 9: r = dv & sv;
        10, 11, 15: r = dv | sv;
        12: r = dv ^ sv;
        13: r = 255 - dv;
        16: r = dv & (255 - sv);
        17: r = (dv + 1) & 255;
        18: r = (dv - 1) & 255;
        19: r = dv;
        20: r = 0;
        default: return;
      endcase
      fl[`ALU_FLAG_V] = (op == 17 && r == 128) || (op == 18 && r == 127);
      if (op == 13)
        fl[`ALU_FLAG_C] = 1'b1;
    end
    dv = r;
    fl[`ALU_FLAG_Z] = (r == 0);
    fl[`ALU_FLAG_N] = r[7];
  endfunction : model

  task automatic wrap_up;
    if (miscompares == 0 && checkCount > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : wrap_up

  initial
  begin
    repeat (40000) @(posedge sysClk);
    miscompares++;
    wrap_up();
  end

  initial
  begin
    seed = 76935;
    repeat (2) @(posedge sysClk);
    rst <= 1'b0;
    // Every register reads zero after reset, and so does the unmapped slot.
    for (int a = 0; a <= 20; a += 4)
      read_check(8'(a), 0);
    for (int op = 0; op < 32; op++)
    begin
      for (int it = 0; it < 8; it++)
      begin
        d = (it < 4) ? edges[it] : ($random(seed) & 255);
        s = (it < 4) ? edges[3 - it] : ($random(seed) & 255);
        hi = $random(seed) & 255;
        f = 6'($random(seed));
        write_reg(`ALU_DEST_OFS, d);
        write_reg(`ALU_SRC_OFS, s);
        write_reg(`ALU_HIGH_OFS, hi);
        write_reg(`ALU_FLAGS_OFS, int'(f));
        write_reg(`ALU_CTRL_OFS, op);
        model(op, s, d, hi, f);
        read_check(`ALU_DEST_OFS, d);
        read_check(`ALU_HIGH_OFS, hi);
        read_check(`ALU_FLAGS_OFS, int'(f));
        read_check(`ALU_CTRL_OFS, op);
      end
    end
    // A write with the low byte lane off, and one to an unmapped slot, change nothing.
    write_reg(`ALU_DEST_OFS, 8'h5A, 4'hE);
    read_check(`ALU_DEST_OFS, d);
    write_reg(8'h14, 8'hA5);
    read_check(8'h14, 0);
    wrap_up();
  end

endmodule : byte_arith_logic_unit_tb
